// File: core/ibhp_regs.vh
// Overview of operation
// - port is active only while the host-port select strap was sampled low.
// - commands, addresses and write data in on the byte bus; read data out on it.
// - write access is command, four address bytes MSB first, then data bytes.
// - read access is command, four address bytes MSB first, dummy byte, data bytes.
// - the first read byte after the address is a dummy; data follows.
// - write address increments by one after every data byte written.
// - read address increments by one after every data byte read.
// - device enable high ends the access; device waits for a new command.
// - device enable high abandons the access at once, even mid-byte.
// - codes 02, D2, 12, A2, 32 are write commands.
// - codes 03, 0B, 3B, BB, 6B, EB are read commands.
`ifndef IBHP_REGS_VH
`define IBHP_REGS_VH
`define IBHP_CMD_PROG_PAGE 8'h02
`define IBHP_CMD_EXT_TWO_PROG 8'hD2
`define IBHP_CMD_EXT_FOUR_PROG 8'h12
`define IBHP_CMD_TWO_IN_PROG 8'hA2
`define IBHP_CMD_FOUR_IN_PROG 8'h32
`define IBHP_CMD_READ 8'h03
`define IBHP_CMD_QUICK_FETCH 8'h0B
`define IBHP_CMD_TWO_OUT_FETCH 8'h3B
`define IBHP_CMD_TWO_IO_FETCH 8'hBB
`define IBHP_CMD_FOUR_OUT_FETCH 8'h6B
`define IBHP_CMD_FOUR_IO_FETCH 8'hEB
`define IBHP_ADDR_BYTES 3'd4
`define IBHP_FIFO_DEPTH 8
`define IBHP_FIFO_AW 3
`endif

// File: core/ibhp_fifo.v
`timescale 1ns/1ps
module ibhp_fifo #(
   parameter WIDTH = 40,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // flush
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output reg out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] count;
   wire empty;
   wire pop;
   wire push;
   assign count = wr_ptr - rd_ptr;
   assign empty = (count == {(AW+1){1'b0}});
   assign in_ready = (count != DEPTH[AW:0]) || (DEPTH == (1 << AW) && !count[AW]);
   assign push = in_valid && in_ready;
   // registered read stage; refilled whenever it is empty or taken
   assign pop = !empty && (!out_valid || out_ready);
   always @(posedge ref_clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
   always @(posedge ref_clk)
   begin
      if (!reset_n || flush)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
            out_data <= mem[rd_ptr[AW-1:0]];
            out_valid <= 1'b1;
         end
         else if (out_ready)
            out_valid <= 1'b0;
      end
   end
endmodule

// File: core/ibhp_port.v
`timescale 1ns/1ps
`include "ibhp_regs.vh"
module ibhp_port #(
   parameter ADDR_W = 32,
   parameter DEPTH = `IBHP_FIFO_DEPTH,
   parameter AW = `IBHP_FIFO_AW
)
(
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // strap
   input wire host_port_select_strap,
   // host pins
   input wire device_enable_n,
   input wire cycle_select_n,
   input wire write_strobe_n,
   input wire read_strobe_n,
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg data_oe,
   // memory write stream
   output wire mem_wr_valid,
   input wire mem_wr_ready,
   output wire [ADDR_W-1:0] mem_wr_addr,
   output wire [7:0] mem_wr_data,
   // memory read request and answer
   output reg mem_rd_req,
   output reg [ADDR_W-1:0] mem_rd_addr,
   input wire mem_rd_valid,
   input wire [7:0] mem_rd_data,
   // status
   output reg parallel_selected,
   output wire write_overrun
);
   localparam S_IDLE = 6'b000001;
   localparam S_CMD = 6'b000010;
   localparam S_ADDR = 6'b000100;
   localparam S_WDATA = 6'b001000;
   localparam S_RDATA = 6'b010000;
   localparam S_SKIP = 6'b100000;

   // three-stage synchronisers on the enable and strobe pins; two stages on the data bus
   reg [2:0] de_s;
   reg [2:0] wr_s;
   reg [2:0] rd_s;
   reg [7:0] d_s1;
   reg [7:0] d_s2;
   reg [2:0] strap_s;
   reg strap_done;
   reg [5:0] state;
   reg [5:0] next_state;
   reg is_read;
   reg [2:0] addr_cnt;
   reg [ADDR_W-1:0] addr;
   reg dummy_pending;
   wire de_act;
   wire wr_act;
   wire wr_act_d;
   wire rd_act;
   wire rd_act_d;
   wire wr_rise;
   wire rd_fall;
   wire rd_rise;
   wire is_wr_cmd;
   wire is_rd_cmd;
   wire fifo_ready;

   // the enable level counts only when stages two and three agree
   assign de_act = parallel_selected && !de_s[1] && !de_s[2];
   assign wr_act = !wr_s[1];
   assign wr_act_d = !wr_s[2];
   assign rd_act = !rd_s[1];
   assign rd_act_d = !rd_s[2];
   // byte is taken at the trailing edge of the write strobe
   assign wr_rise = de_act && !wr_act && wr_act_d;
   assign rd_fall = de_act && rd_act && !rd_act_d;
   assign rd_rise = de_act && !rd_act && rd_act_d;

   always @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         de_s <= 3'b111;
         wr_s <= 3'b111;
         rd_s <= 3'b111;
         d_s1 <= 8'h00;
         d_s2 <= 8'h00;
      end
      else
      begin
         de_s <= {de_s[1:0], device_enable_n};
         // cycle select gates both strobes
         wr_s <= {wr_s[1:0], write_strobe_n | cycle_select_n};
         rd_s <= {rd_s[1:0], read_strobe_n | cycle_select_n};
         d_s1 <= data_in;
         d_s2 <= d_s1;
      end
   end

   // strap synchroniser runs through reset so it has settled by release
   always @(posedge ref_clk)
   begin
      strap_s <= {strap_s[1:0], host_port_select_strap};
   end

   // strap caught once after reset release, when stages two and three agree
   always @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         strap_done <= 1'b0;
         parallel_selected <= 1'b0;
      end
      else if (!strap_done && (strap_s[1] == strap_s[2]))
      begin
         strap_done <= 1'b1;
         parallel_selected <= !strap_s[2];
      end
   end

   assign is_wr_cmd = (d_s2 == `IBHP_CMD_PROG_PAGE) || (d_s2 == `IBHP_CMD_EXT_TWO_PROG) ||
      (d_s2 == `IBHP_CMD_EXT_FOUR_PROG) || (d_s2 == `IBHP_CMD_TWO_IN_PROG) ||
      (d_s2 == `IBHP_CMD_FOUR_IN_PROG);
   assign is_rd_cmd = (d_s2 == `IBHP_CMD_READ) || (d_s2 == `IBHP_CMD_QUICK_FETCH) ||
      (d_s2 == `IBHP_CMD_TWO_OUT_FETCH) || (d_s2 == `IBHP_CMD_TWO_IO_FETCH) ||
      (d_s2 == `IBHP_CMD_FOUR_OUT_FETCH) || (d_s2 == `IBHP_CMD_FOUR_IO_FETCH);

   always @*
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (de_act)
               next_state = S_CMD;
         S_CMD:
            if (wr_rise)
               next_state = (is_wr_cmd || is_rd_cmd) ? S_ADDR : S_SKIP;
         S_ADDR:
            if (wr_rise && addr_cnt == `IBHP_ADDR_BYTES - 3'd1)
               next_state = is_read ? S_RDATA : S_WDATA;
         S_WDATA:
            next_state = S_WDATA;
         S_RDATA:
            next_state = S_RDATA;
         S_SKIP:
            next_state = S_SKIP;
         default:
            next_state = S_IDLE;
      endcase
      if (!de_act)
         next_state = S_IDLE;
   end

   // write bytes queue up with their address; the memory side may stall
   ibhp_fifo #(
      .WIDTH(ADDR_W + 8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_wfifo (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .flush(1'b0),
      .in_valid(state == S_WDATA && wr_rise),
      .in_ready(fifo_ready),
      .in_data({addr, d_s2}),
      .out_valid(mem_wr_valid),
      .out_ready(mem_wr_ready),
      .out_data({mem_wr_addr, mem_wr_data})
   );
   // host has no wait pin, so a byte offered to a full queue is lost and flagged
   assign write_overrun = (state == S_WDATA) && wr_rise && !fifo_ready;

   always @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state <= S_IDLE;
         is_read <= 1'b0;
         addr_cnt <= 3'd0;
         addr <= {ADDR_W{1'b0}};
         dummy_pending <= 1'b0;
         mem_rd_req <= 1'b0;
         mem_rd_addr <= {ADDR_W{1'b0}};
         data_out <= 8'h00;
         data_oe <= 1'b0;
      end
      else
      begin
         state <= next_state;
         mem_rd_req <= 1'b0;
         if (state == S_CMD && wr_rise)
         begin
            is_read <= is_rd_cmd;
            addr_cnt <= 3'd0;
         end
         if (state == S_ADDR && wr_rise)
         begin
            addr <= {addr[ADDR_W-9:0], d_s2};
            addr_cnt <= addr_cnt + 3'd1;
            if (addr_cnt == `IBHP_ADDR_BYTES - 3'd1)
            begin
               dummy_pending <= 1'b1;
               // prefetch the first byte during the dummy cycle
               mem_rd_req <= is_read;
               mem_rd_addr <= {addr[ADDR_W-9:0], d_s2};
            end
         end
         if (state == S_WDATA && wr_rise && fifo_ready)
            addr <= addr + 1'b1;
         if (state == S_RDATA && rd_fall)
            data_oe <= 1'b1;
         if (state == S_RDATA && rd_rise)
         begin
            data_oe <= 1'b0;
            if (dummy_pending)
               dummy_pending <= 1'b0;
            else
            begin
               addr <= addr + 1'b1;
               mem_rd_req <= 1'b1;
               mem_rd_addr <= addr + 1'b1;
            end
         end
         if (mem_rd_valid)
            data_out <= mem_rd_data;
         if (!de_act)
         begin
            data_oe <= 1'b0;
            dummy_pending <= 1'b0;
         end
      end
   end
endmodule

// File: testbench/ibhp_props.sv
`timescale 1ns/1ps
module ibhp_props (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // host pins
   input wire device_enable_n,
   input wire cycle_select_n,
   input wire read_strobe_n,
   // design outputs and the memory write ready
   input wire [7:0] data_out,
   input wire data_oe,
   input wire mem_wr_valid,
   input wire mem_wr_ready,
   input wire [31:0] mem_wr_addr,
   input wire [7:0] mem_wr_data,
   input wire mem_rd_req,
   input wire parallel_selected,
   input wire write_overrun
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sel_gate_a: assert property (!parallel_selected |-> !mem_wr_valid && !mem_rd_req)
      else $error("unselected port active");
   wr_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
      && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write not held");
   rd_pulse_a: assert property (mem_rd_req |=> !mem_rd_req)
      else $error("read request too long");
   end_idle_a: assert property (device_enable_n [*6] |-> !data_oe && !mem_rd_req)
      else $error("activity after enable released");
   oe_release_a: assert property (read_strobe_n [*6] |-> !data_oe)
      else $error("bus driven without read strobe");
   oe_cause_a: assert property ($rose(data_oe) |-> !read_strobe_n && !cycle_select_n)
      else $error("bus driven without read cycle");
   oe_data_a: assert property (data_oe ##1 data_oe |-> $stable(data_out))
      else $error("read byte changed while driven");
   ovr_full_a: assert property (write_overrun |-> mem_wr_valid)
      else $error("overrun with room left");
endmodule

bind ibhp_port ibhp_props i_props (.ref_clk(ref_clk), .reset_n(reset_n),
   .device_enable_n(device_enable_n), .cycle_select_n(cycle_select_n),
   .read_strobe_n(read_strobe_n), .data_out(data_out), .data_oe(data_oe),
   .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
   .mem_wr_data(mem_wr_data), .mem_rd_req(mem_rd_req),
   .parallel_selected(parallel_selected), .write_overrun(write_overrun));

// File: testbench/ibhp_mem_model.sv
`timescale 1ns/1ps
module ibhp_mem_model (
   // control
   input wire ref_clk,
   input wire stall,
   input wire slow,
   // write stream
   input wire mem_wr_valid,
   output logic mem_wr_ready,
   input wire [31:0] mem_wr_addr,
   input wire [7:0] mem_wr_data,
   // read request
   input wire mem_rd_req,
   input wire [31:0] mem_rd_addr,
   output logic mem_rd_valid,
   output logic [7:0] mem_rd_data
);
   logic [7:0] mem [0:255];
   logic [7:0] a;
   logic [1:0] delay;
   logic primed = 1'b0;
   // one process owns the array and every output; array preset on the first edge
   always @(posedge ref_clk)
   begin
      mem_wr_ready <= !stall;
      if (!primed)
      begin
         for (int i = 0; i < 256; i++) mem[i] <= 8'(i) ^ 8'hA5;
         primed <= 1'b1;
         delay <= 2'd0;
         a <= 8'h00;
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 8'h00;
      end
      else
      begin
         if (mem_wr_valid && mem_wr_ready)
            mem[mem_wr_addr[7:0]] <= mem_wr_data;
         mem_rd_valid <= (delay == 2'd1) || (delay == 2'd0 && mem_rd_req && !slow);
         if (delay == 2'd1)
            mem_rd_data <= mem[a];
         else if (delay == 2'd0 && mem_rd_req && !slow)
            mem_rd_data <= mem[mem_rd_addr[7:0]];
         else if (mem_rd_valid)
            // stale byte inverted so a late sample shows up
            mem_rd_data <= ~mem[a];
         if (delay != 2'd0)
            delay <= delay - 2'd1;
         else if (mem_rd_req)
         begin
            a <= mem_rd_addr[7:0];
            if (slow)
               delay <= 2'd3;
         end
      end
   end
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 0, reset_n = 0, strap = 0, de_n = 1, cs_n = 1, wr_n = 1, rd_n = 1;
   logic stall = 0, slow = 0, ovr = 0;
   logic [7:0] din = 8'h00, v;
   logic [7:0] shadow [0:255];
   wire [7:0] dout, wd, rdd;
   wire oe, wv, wrdy, req, rv, sel, wov;
   wire [31:0] wa, ra;
   int n_fail = 0, num_checks = 0, nwv = 0;
   ibhp_port i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .host_port_select_strap(strap),
      .device_enable_n(de_n), .cycle_select_n(cs_n), .write_strobe_n(wr_n),
      .read_strobe_n(rd_n), .data_in(oe ? dout : din), .data_out(dout), .data_oe(oe),
      .mem_wr_valid(wv), .mem_wr_ready(wrdy), .mem_wr_addr(wa), .mem_wr_data(wd),
      .mem_rd_req(req), .mem_rd_addr(ra), .mem_rd_valid(rv), .mem_rd_data(rdd),
      .parallel_selected(sel), .write_overrun(wov));
   ibhp_mem_model i_mem (.ref_clk(ref_clk), .stall(stall), .slow(slow), .mem_wr_valid(wv),
      .mem_wr_ready(wrdy), .mem_wr_addr(wa), .mem_wr_data(wd), .mem_rd_req(req),
      .mem_rd_addr(ra), .mem_rd_valid(rv), .mem_rd_data(rdd));
   initial forever #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (wov) ovr <= 1;
      if (wv) nwv <= nwv + 1;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task put(input logic [7:0] b);
      din = b;
      cs_n = 0;
      wr_n = 0;
      wait_n(6);
      cs_n = 1;
      wr_n = 1;
      wait_n(1);
      din = ~b;
      wait_n(6);
   endtask
   task get();
      cs_n = 0;
      rd_n = 0;
      wait_n(6);
      check(oe, 1);
      v = dout;
      cs_n = 1;
      rd_n = 1;
      wait_n(8);
   endtask
   task head(input logic [7:0] cmd, input logic [31:0] a);
      de_n = 0;
      wait_n(2);
      put(cmd);
      for (int i = 3; i >= 0; i--) put(a[8*i +: 8]);
   endtask
   // mode 0 write, 1 read, 2 write that must be ignored
   task access(input logic [7:0] cmd, input logic [31:0] a, input int n, input int mode);
      head(cmd, a);
      if (mode == 1)
         get();
      for (int i = 0; i < n; i++)
      begin
         if (mode == 1)
         begin
            get();
            check(v, shadow[8'(a + i)]);
         end
         else
         begin
            put(8'h3C ^ 8'(i));
            if (mode == 0)
               shadow[8'(a + i)] = 8'h3C ^ 8'(i);
         end
      end
      de_n = 1;
      wait_n(8);
   endtask
   task t_cmds;
      logic [7:0] wc [5];
      logic [7:0] rc [6];
      wc = '{8'h02, 8'hD2, 8'h12, 8'hA2, 8'h32};
      rc = '{8'h03, 8'h0B, 8'h3B, 8'hBB, 8'h6B, 8'hEB};
      for (int k = 0; k < 5; k++) access(wc[k], 32'h0000_0010 * k, 2, 0);
      for (int k = 0; k < 6; k++)
      begin
         slow = k[0];
         access(rc[k], 32'h0000_000F * k, 3, 1);
      end
      $display("command test done");
   endtask
   task t_odd;
      access(8'h05, 32'h0000_0080, 2, 2);
      access(8'h03, 32'h0000_0080, 2, 1);
      head(8'h02, 32'h0000_00C0);
      put(8'h11);
      shadow[8'hC0] = 8'h11;
      din = 8'h77;
      cs_n = 0;
      wr_n = 0;
      wait_n(6);
      de_n = 1;
      wait_n(2);
      cs_n = 1;
      wr_n = 1;
      wait_n(8);
      access(8'h0B, 32'h0000_00C0, 2, 1);
      $display("ignore and abort test done");
   endtask
   task t_fifo;
      stall = 1;
      access(8'h02, 32'h0000_0040, 10, 0);
      check(ovr, 1);
      stall = 0;
      wait_n(30);
      // the tenth byte met a full queue, so its location keeps the preset pattern
      shadow[8'h49] = 8'h49 ^ 8'hA5;
      access(8'h03, 32'h0000_0040, 10, 1);
      $display("buffer test done");
   endtask
   task t_strap;
      int n0;
      strap = 1;
      do_reset();
      check(sel, 0);
      n0 = nwv;
      access(8'h02, 32'h0000_0020, 2, 2);
      check(nwv, n0);
      $display("strap test done");
   endtask
   task do_reset;
      reset_n = 0;
      wait_n(8);
      reset_n = 1;
      wait_n(6);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'hA5;
      do_reset();
      check(sel, 1);
      t_cmds();
      t_odd();
      t_fifo();
      t_strap();
      complete_run();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end
endmodule
